/* rtl/lpt_pkg.sv */
package lpt_pkg;

   // Host port offsets within the four-address block
   localparam logic [7:0] DATA_IN_PRINTER_COUNT_OFS = 8'hC2;
   localparam logic [7:0] SOFT_RESET_HOST_COUNT_OFS = 8'hC3;
   localparam int unsigned BLOCK_LSB                = 2;
   localparam int unsigned SOFT_RESET_BIT           = 0;

   // Buffer geometry
   localparam int unsigned PTR_W      = 12;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned BANK_W     = 2;
   localparam int unsigned BANKS      = 4;
   localparam int unsigned COUNT_LSB  = 4;

   // Board clock choices and the system clock
   localparam int unsigned SYS_CLK_HZ   = 200_000_000;
   localparam int unsigned BOARD_FAST_HZ = 2_000_000;
   localparam int unsigned BOARD_SLOW_HZ = 1_000_000;
   localparam int unsigned DIV_W        = 8;
   localparam logic [DIV_W-1:0] DIV_FAST =
      DIV_W'(SYS_CLK_HZ / BOARD_FAST_HZ);
   localparam logic [DIV_W-1:0] DIV_SLOW =
      DIV_W'(SYS_CLK_HZ / BOARD_SLOW_HZ);

   // Printer transfer sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_GRANT,
      ST_FETCH,
      ST_STROBE
   } seq_state_type;

   // One-hot bank select from the top address bits
   function automatic logic [BANKS-1:0] bank_decode
      (input logic [BANK_W-1:0] hi);
      bank_decode = BANKS'(1) << hi;
   endfunction : bank_decode

endpackage : lpt_pkg

/* rtl/ram_bus_if.sv */
`timescale 1ns/1ps
interface ram_bus_if
   import lpt_pkg::*;
();
   logic [PTR_W-1:0]  addr;
   logic [BYTE_W-1:0] wdata;
   logic [BYTE_W-1:0] rdata;
   logic              we;
   logic [BANKS-1:0]  bank_sel;

   modport ctrl (output addr, output wdata, output we, output bank_sel,
                 input rdata);
   modport mem  (input addr, input wdata, input we, input bank_sel,
                 output rdata);
endinterface : ram_bus_if

/* rtl/bus_sync.sv */
`timescale 1ns/1ps
module bus_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         meta_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : bus_sync

/* rtl/buffer_ram.sv */
`timescale 1ns/1ps
module buffer_ram
   import lpt_pkg::*;
(
   input  wire logic clk_i,
   ram_bus_if.mem    ram
);
   localparam int unsigned BANK_DEPTH = 2 ** (PTR_W - BANK_W);

   logic [BYTE_W-1:0] mem_q [BANKS][BANK_DEPTH];
   logic [BYTE_W-1:0] bank_rd [BANKS];
   logic [BYTE_W-1:0] rdata_q;
   logic [PTR_W-BANK_W-1:0] low_addr;

   assign low_addr  = ram.addr[PTR_W-BANK_W-1:0];
   assign ram.rdata = rdata_q;

   // Each bank writes only when its select is up
   for (genvar b = 0; b < BANKS; b++)
   begin : g_bank
      always_ff @(posedge clk_i)
      begin
         if (ram.we && ram.bank_sel[b])
            mem_q[b][low_addr] <= ram.wdata;
      end
      assign bank_rd[b] = mem_q[b][low_addr];
   end

   // Registered read from the selected bank
   always_ff @(posedge clk_i)
   begin
      rdata_q <= bank_rd[ram.addr[PTR_W-1:PTR_W-BANK_W]];
   end
endmodule : buffer_ram

/* rtl/buffered_printer_port.sv */
`timescale 1ns/1ps
// Contract
// - Decode four-port block on address bits 2-7
// - Board clock 2 MHz default, or 1 MHz
// - Printer status inputs optionally inverted
// - Strobe output polarity selectable
// - Data port write captures and holds byte
// - Control port write, bit 0 resets board
// - Bus preset also resets board
// - Data port read gives printer count/16
// - Control port read gives host count/16
// - Write strobe loads register, sets pending
// - Pending raises grant, write pointer addresses RAM
// - RAM write stores byte, advances write pointer
// - Equal pointers flag empty buffer
// - Read needs printer ready, no grant/empty/strobe
// - Read loads RAM byte into printer latch
// - Latch pulse advances read pointer once
// - Mux picks pointer; top bits select bank
// - Strobe drops when printer drops demand
// - Captured byte is always low data byte
// - Grant only when no printer read active
module buffered_printer_port
   import lpt_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic [7:0]        addr_i,
   input  wire logic [15:0]       dout_i,
   input  wire logic              sout_i,
   input  wire logic              sinp_i,
   input  wire logic              pwr_n_i,
   input  wire logic              pdbin_i,
   input  wire logic              preset_n_i,
   output logic      [7:0]        din_o,
   output logic                   din_oe_o,
   input  wire logic [5:0]        block_sel_i,
   input  wire logic              clk_half_i,
   input  wire logic              status_invert_i,
   input  wire logic              strobe_invert_i,
   input  wire logic              prn_ready_i,
   input  wire logic              prn_online_i,
   input  wire logic              prn_demand_i,
   output logic      [BYTE_W-1:0] prn_data_o,
   output logic                   prn_strobe_o
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   // Ten control pins, block strap, address and low data byte
   localparam int unsigned SYNC_W = 32;

   logic [SYNC_W-1:0] sync_s;
   logic [5:0]        blk_s;
   logic [7:0]        addr_s;
   logic [BYTE_W-1:0] dout_s;
   logic sout_s, sinp_s, pwr_n_s, pdbin_s, preset_n_s;
   logic half_s, sinv_s, oinv_s, ready_s, online_s;
   logic demand_s;

   bus_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .async_i ({sout_i, sinp_i, pwr_n_i, pdbin_i, preset_n_i,
                 clk_half_i, status_invert_i, strobe_invert_i,
                 prn_ready_i, prn_online_i, block_sel_i, addr_i,
                 dout_i[BYTE_W-1:0]}),
      .sync_o  (sync_s)
   );

   bus_sync #(.WIDTH(1)) u_sync_dem (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .async_i (prn_demand_i),
      .sync_o  (demand_s)
   );

   assign {sout_s, sinp_s, pwr_n_s, pdbin_s, preset_n_s,
           half_s, sinv_s, oinv_s, ready_s, online_s,
           blk_s, addr_s, dout_s} = sync_s;

   ////////////////////////////////////////////////////////////////////////
   // Host port decode

   logic block_hit, data_sel, ctrl_sel;
   logic wr_act, wr_act_q, host_wr_edge;
   logic host_data_write_strobe, control_port_write;
   logic printer_count_read_gate, host_count_read_gate;
   logic soft_rst_q, board_rst;

   // Block compare and port select
   assign block_hit = addr_s[7:BLOCK_LSB] == blk_s;
   assign data_sel  = block_hit &&
      addr_s[BLOCK_LSB-1:0] == DATA_IN_PRINTER_COUNT_OFS[BLOCK_LSB-1:0];
   assign ctrl_sel  = block_hit &&
      addr_s[BLOCK_LSB-1:0] == SOFT_RESET_HOST_COUNT_OFS[BLOCK_LSB-1:0];

   // Write cycle edge, read gates
   assign wr_act                  = sout_s && !pwr_n_s;
   assign host_wr_edge            = wr_act && !wr_act_q;
   assign host_data_write_strobe  = host_wr_edge && data_sel;
   assign control_port_write      = host_wr_edge && ctrl_sel;
   assign printer_count_read_gate = sinp_s && pdbin_s && data_sel;
   assign host_count_read_gate    = sinp_s && pdbin_s && ctrl_sel;
   assign din_oe_o = printer_count_read_gate || host_count_read_gate;

   // Board reset from system, bus preset or software
   assign board_rst = srst_i || !preset_n_s || soft_rst_q;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         wr_act_q   <= 1'b0;
         soft_rst_q <= 1'b0;
      end
      else
      begin
         wr_act_q   <= wr_act;
         soft_rst_q <= control_port_write &&
                       dout_s[SOFT_RESET_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Board clock tick

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_limit;
   logic             tick;

   assign div_limit = half_s ? DIV_SLOW : DIV_FAST;
   assign tick      = div_q == div_limit - DIV_W'(1);

   always_ff @(posedge clk_i)
   begin
      if (srst_i || tick)
         div_q <= '0;
      else
         div_q <= div_q + DIV_W'(1);
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffer pointers and sequencer

   ram_bus_if ram ();

   buffer_ram u_ram (
      .clk_i (clk_i),
      .ram   (ram)
   );

   seq_state_type     state_q, state_d;
   logic [PTR_W-1:0]  write_pointer_q, read_pointer_q;
   logic [BYTE_W-1:0] out_reg_q, prn_data_q;
   logic [7:0]        din_q;
   logic              data_pending_q, strobe_q, strobe_pin_q;
   logic              host_write_grant, addr_equal;
   logic              rdy_a, online_a, demand_a, read_start;
   logic              ram_write, read_count_advance;

   // Status inputs with optional inversion
   assign rdy_a    = ready_s ^ sinv_s;
   assign online_a = online_s ^ sinv_s;
   assign demand_a = demand_s ^ sinv_s;

   assign addr_equal       = read_pointer_q == write_pointer_q;
   assign host_write_grant = state_q == ST_GRANT;
   assign read_start = rdy_a && online_a && demand_a &&
                       !host_write_grant && !addr_equal &&
                       !strobe_q;
   assign ram_write          = host_write_grant && tick;
   assign read_count_advance =
      state_q == ST_FETCH && tick;

   // RAM address mux and bank decode
   assign ram.addr     = host_write_grant ? write_pointer_q
                                          : read_pointer_q;
   assign ram.bank_sel =
      bank_decode(ram.addr[PTR_W-1:PTR_W-BANK_W]);
   assign ram.wdata    = out_reg_q;
   assign ram.we       = ram_write;

   // Next state; pending write wins when no read runs
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (tick && data_pending_q)
               state_d = ST_GRANT;
            else if (tick && read_start)
               state_d = ST_FETCH;
         ST_GRANT:
            if (tick)
               state_d = ST_IDLE;
         ST_FETCH:
            if (tick)
               state_d = ST_STROBE;
         ST_STROBE:
            if (tick && !demand_a)
               state_d = ST_IDLE;  // one strobe per byte
         default:
            state_d = ST_IDLE;
      endcase
   end

   // Sequencer and pointers
   always_ff @(posedge clk_i)
   begin
      if (board_rst)
      begin
         state_q         <= ST_IDLE;
         write_pointer_q <= '0;
         read_pointer_q  <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (ram_write)
            write_pointer_q <= write_pointer_q + PTR_W'(1);
         if (read_count_advance)
            read_pointer_q <= read_pointer_q + PTR_W'(1);
      end
   end

   // Host byte register; a new write beats the clear
   always_ff @(posedge clk_i)
   begin
      if (board_rst)
      begin
         data_pending_q <= 1'b0;
         out_reg_q      <= '0;
      end
      else if (host_data_write_strobe)
      begin
         out_reg_q      <= dout_s;
         data_pending_q <= 1'b1;
      end
      else if (ram_write)
         data_pending_q <= 1'b0;
   end

   // Printer latch and strobe, strobe one tick after latch
   always_ff @(posedge clk_i)
   begin
      if (board_rst)
      begin
         prn_data_q <= '0;
         strobe_q   <= 1'b0;
      end
      else
      begin
         if (read_count_advance)
            prn_data_q <= ram.rdata;
         if (tick && state_q == ST_STROBE && !strobe_q && demand_a)
            strobe_q <= 1'b1;
         else if (tick && strobe_q && !demand_a)
            strobe_q <= 1'b0;
      end
   end

   // Count read data and pin drivers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         din_q        <= '0;
         strobe_pin_q <= 1'b0;
      end
      else
      begin
         din_q <= printer_count_read_gate
                  ? read_pointer_q[PTR_W-1:COUNT_LSB]
                  : write_pointer_q[PTR_W-1:COUNT_LSB];
         strobe_pin_q <= strobe_q ^ oinv_s;
      end
   end

   assign din_o        = din_q;
   assign prn_data_o   = prn_data_q;
   assign prn_strobe_o = strobe_pin_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   AST_CAPTURE: assert property (
      @(posedge clk_i) disable iff (board_rst)
      host_data_write_strobe |=> data_pending_q &&
         out_reg_q == $past(dout_s))
      else $error("Host byte not captured");

   AST_GRANT_NO_READ: assert property (
      @(posedge clk_i) disable iff (board_rst)
      host_write_grant |-> !strobe_q)
      else $error("Grant during printer read");

   AST_WRITE_ADV: assert property (
      @(posedge clk_i) disable iff (board_rst)
      ram_write |=> write_pointer_q == $past(write_pointer_q) + PTR_W'(1)
         && state_q == ST_IDLE)
      else $error("Write pointer not advanced");

   AST_EMPTY_HOLD: assert property (
      @(posedge clk_i) disable iff (board_rst)
      (state_q == ST_IDLE && addr_equal && !data_pending_q)
         |=> state_q != ST_FETCH)
      else $error("Read from empty buffer");

   AST_READ_ADV: assert property (
      @(posedge clk_i) disable iff (board_rst)
      read_count_advance |=> read_pointer_q ==
         $past(read_pointer_q) + PTR_W'(1) && prn_data_q == $past(ram.rdata))
      else $error("Read pointer or latch wrong");

   AST_STROBE_DROP: assert property (
      @(posedge clk_i) disable iff (board_rst)
      (tick && strobe_q && !demand_a) |=> !strobe_q)
      else $error("Strobe held after demand dropped");

   AST_BANK: assert property (
      @(posedge clk_i) disable iff (board_rst)
      $onehot(ram.bank_sel) &&
         ram.bank_sel[ram.addr[PTR_W-1:PTR_W-BANK_W]])
      else $error("Bank select wrong");

   AST_COUNT_READ: assert property (
      @(posedge clk_i) disable iff (board_rst)
      printer_count_read_gate
         |=> din_o == $past(read_pointer_q[PTR_W-1:COUNT_LSB]))
      else $error("Printer count read wrong");

   AST_SOFT_RESET: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (control_port_write && dout_s[SOFT_RESET_BIT]) |=> ##1
         (write_pointer_q == '0 && read_pointer_q == '0 &&
          !data_pending_q && !strobe_q))
      else $error("Software reset did not clear");

endmodule : buffered_printer_port

/* sim/printer_model.sv */
`timescale 1ns/1ps
module printer_model
(
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       online_en_i,
   input  wire logic       slow_i,
   input  wire logic       inv_status_i,
   input  wire logic       inv_strobe_i,
   input  wire logic [7:0] data_i,
   input  wire logic       strobe_i,
   output logic            ready_o,
   output logic            online_o,
   output logic            demand_o
);
   logic       dem_q;
   int         hold_q;
   logic [7:0] got[$];
   wire        active = strobe_i ^ inv_strobe_i;

   ////////////////////////////////////////////////////////////////////////
   // Demand drops on a strobe, rises again after a short or long pause
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         dem_q  <= 1'b1;
         hold_q <= 0;
      end
      else if (dem_q && active && online_en_i)
      begin
         got.push_back(data_i);
         dem_q  <= 1'b0;
         hold_q <= slow_i ? 300 : 5;
      end
      else if (!dem_q && !active)
      begin
         if (hold_q > 0)
            hold_q <= hold_q - 1;
         else
            dem_q <= 1'b1;
      end
   end

   // Status lines with the strapped sense
   assign ready_o  = 1'b1 ^ inv_status_i;
   assign online_o = online_en_i ^ inv_status_i;
   assign demand_o = (dem_q & online_en_i) ^ inv_status_i;
endmodule : printer_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import lpt_pkg::*;
   typedef struct {logic [15:0] dout; logic [7:0] exp;} row_type;
   logic        clk_i = 0, srst_i = 1, sout_i = 0, sinp_i = 0;
   logic        pwr_n_i = 1, pdbin_i = 0, preset_n_i = 1, clk_half_i = 0;
   logic        status_invert_i = 0, strobe_invert_i = 0;
   logic        online_en = 0, slow = 0, oe;
   logic [5:0]  blk = 6'h30;
   logic [7:0]  addr_i = 8'h00, din_o, prn_data_o, v;
   logic [15:0] dout_i = 16'h0000;
   logic        din_oe_o, prn_strobe_o, rdy, onl, dem;
   int          n_fail = 0, num_checks = 0, cyc, base;
   row_type     rows[16];

   always #2.5 clk_i = ~clk_i;

   buffered_printer_port u_buffered_printer_port (.clk_i(clk_i),
      .srst_i(srst_i), .addr_i(addr_i), .dout_i(dout_i), .sout_i(sout_i),
      .sinp_i(sinp_i), .pwr_n_i(pwr_n_i), .pdbin_i(pdbin_i),
      .preset_n_i(preset_n_i), .din_o(din_o), .din_oe_o(din_oe_o),
      .block_sel_i(blk), .clk_half_i(clk_half_i),
      .status_invert_i(status_invert_i), .strobe_invert_i(strobe_invert_i),
      .prn_ready_i(rdy), .prn_online_i(onl), .prn_demand_i(dem),
      .prn_data_o(prn_data_o), .prn_strobe_o(prn_strobe_o));

   printer_model u_printer_model (.clk_i(clk_i), .srst_i(srst_i),
      .online_en_i(online_en), .slow_i(slow), .inv_status_i(status_invert_i),
      .inv_strobe_i(strobe_invert_i), .data_i(prn_data_o),
      .strobe_i(prn_strobe_o), .ready_o(rdy), .online_o(onl),
      .demand_o(dem));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus cycles
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic io_wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr_i = a;
      dout_i = d;
      sout_i = 1;
      pwr_n_i = 0;
      repeat (6) @(negedge clk_i);
      sout_i = 0;
      pwr_n_i = 1;
      repeat (450) @(negedge clk_i);
   endtask : io_wr

   task automatic io_rd(input logic [7:0] a, output logic [7:0] d,
                        output logic e);
      @(negedge clk_i);
      addr_i = a;
      sinp_i = 1;
      pdbin_i = 1;
      repeat (6) @(negedge clk_i);
      d = din_o;
      e = din_oe_o;
      sinp_i = 0;
      pdbin_i = 0;
      repeat (4) @(negedge clk_i);
   endtask : io_rd

   // Waits for n captured characters, bounded
   task automatic wait_got(input int n, output int c);
      c = 0;
      while (u_printer_model.got.size() < n && c < 20000)
      begin
         @(negedge clk_i);
         c++;
      end
      if (u_printer_model.got.size() < n)
      begin
         n_fail++;
         summarize();
      end
   endtask : wait_got

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      for (int i = 0; i < 16; i++)
      begin
         rows[i].dout = {8'hF0 - 8'(i), 8'h41 + 8'(i * 5)};
         rows[i].exp  = 8'h41 + 8'(i * 5);
      end
      repeat (4) @(negedge clk_i);
      srst_i = 0;
      repeat (4) @(negedge clk_i);
      chk(prn_strobe_o, 0);
      chk(din_oe_o, 0);
      // Table rows fill the buffer while the printer is off line
      foreach (rows[i])
         io_wr(DATA_IN_PRINTER_COUNT_OFS, rows[i].dout);
      io_rd(SOFT_RESET_HOST_COUNT_OFS, v, oe);
      chk(v, 8'h01);
      chk(oe, 1);
      io_rd(DATA_IN_PRINTER_COUNT_OFS, v, oe);
      chk(v, 8'h00);
      chk(u_printer_model.got.size(), 0);
      // Foreign block and unused offset are ignored
      io_wr(8'h82, 16'h0055);
      io_wr(8'hC0, 16'h0055);
      io_rd(8'h82, v, oe);
      chk(oe, 0);
      io_rd(SOFT_RESET_HOST_COUNT_OFS, v, oe);
      chk(v, 8'h01);
      // Drain at the fast board clock
      online_en = 1;
      wait_got(1, cyc);
      chk(cyc <= 320, 1);
      wait_got(16, cyc);
      foreach (rows[i])
         chk(u_printer_model.got[i], rows[i].exp);
      io_rd(DATA_IN_PRINTER_COUNT_OFS, v, oe);
      chk(v, 8'h01);
      repeat (600) @(negedge clk_i);
      chk(u_printer_model.got.size(), 16);
      // Writes while a slow printer is busy reading
      slow = 1;
      io_wr(DATA_IN_PRINTER_COUNT_OFS, 16'h1234);
      io_wr(DATA_IN_PRINTER_COUNT_OFS, 16'hAB9C);
      wait_got(18, cyc);
      chk(u_printer_model.got[16], 8'h34);
      chk(u_printer_model.got[17], 8'h9C);
      slow = 0;
      // Control write without and with the reset bit
      io_wr(SOFT_RESET_HOST_COUNT_OFS, 16'h00FE);
      io_rd(SOFT_RESET_HOST_COUNT_OFS, v, oe);
      chk(v, 8'h01);
      io_wr(SOFT_RESET_HOST_COUNT_OFS, 16'hFF01);
      io_rd(SOFT_RESET_HOST_COUNT_OFS, v, oe);
      chk(v, 8'h00);
      io_rd(DATA_IN_PRINTER_COUNT_OFS, v, oe);
      chk(v, 8'h00);
      // A moved block answers at its own address only
      blk = 6'h10;
      io_rd(8'h43, v, oe);
      chk(oe, 1);
      chk(v, 8'h00);
      io_rd(SOFT_RESET_HOST_COUNT_OFS, v, oe);
      chk(oe, 0);
      blk = 6'h30;
      // Bus preset discards a queued byte
      online_en = 0;
      io_wr(DATA_IN_PRINTER_COUNT_OFS, 16'h0077);
      preset_n_i = 0;
      repeat (8) @(negedge clk_i);
      preset_n_i = 1;
      repeat (8) @(negedge clk_i);
      online_en = 1;
      repeat (800) @(negedge clk_i);
      chk(u_printer_model.got.size(), 18);
      // Inverted senses and the slow board clock
      online_en = 0;
      status_invert_i = 1;
      strobe_invert_i = 1;
      clk_half_i = 1;
      repeat (10) @(negedge clk_i);
      chk(prn_strobe_o, 1);
      io_wr(DATA_IN_PRINTER_COUNT_OFS, 16'h0066);
      online_en = 1;
      wait_got(19, cyc);
      chk(cyc >= 390, 1);
      chk(u_printer_model.got[18], 8'h66);
      summarize();
   end
endmodule : tb_top
